// ==== verilog/timer16_output_compare_unit.sv ====
// Sixteen-bit timer with three output compare channels and pin override.
//
// Notes on behaviour
// R1: With double buffering, compare writes go to the buffer; otherwise straight to live.
// R2: Compare values change only by writes and are read directly, not via staging.
// R3: High byte goes to staging; low byte write loads all sixteen bits at once.
// R4: Force strobe in non-PWM modes acts like a match, without flag or counter change.
// R5: A counter write blocks every compare match in the next timer tick.
// R6: Counter written equal to a variable TOP misses that TOP and runs to 0xFFFF.
// R7: Waveform bits keep their value across waveform mode changes.
// R8: Output action selects are unbuffered and apply from the next match.
// R9: Reset clears every waveform bit to 0.
// R10: Nonzero action select makes the waveform bit replace the port output value.
// R11: Waveform shows on the pin only while the direction bit selects output.
// R12: Action select 0 leaves the waveform bit unchanged on a match.
// R13: Action selects do not reach any capture logic.
// R14: Counting depends only on the waveform mode, never on action selects.
// R15: Non-PWM actions set, clear or toggle; PWM actions pick non-inverted or inverted.
// R16: Normal mode counts up only and wraps from 0xFFFF to 0x0000.
// R17: Overflow flag sets in the tick the counter becomes zero, but not at a compare-A TOP in CTC mode; counting never clears it.
// R18: In Normal mode a counter write is accepted at any time.
// R19: Double buffering active in PWM modes only; buffer moves to live at TOP.
// R20: Equality sets the channel match flag on the tick; enabled flags raise requests.
// R21: Flags clear on interrupt acknowledge or on a written one.
// R22: A counter write sets a block flag that the next timer tick clears.
`timescale 1ns/1ps

`include "timer16_cfg.svh"

module timer16_output_compare_unit (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_timer_tick,
  input wire timer16_pkg::bus_req_s i_bus,
  input wire logic [3:0] i_irq_ack,
  output logic [7:0] o_rdata,
  output logic [2:0] o_pin_out,
  output logic [2:0] o_pin_oe,
  output logic [3:0] o_irq
);
  import timer16_pkg::*;

  logic [5:0] action_reg;
  logic [5:0] action_next;
  logic [3:0] mode_reg;
  logic [3:0] mode_next;
  logic [15:0] counter_value_reg;
  logic [15:0] counter_value_next;
  logic [7:0] temp_reg;
  logic [7:0] temp_next;
  logic block_reg;
  logic block_next;
  logic [3:0] flag_reg;
  logic [3:0] flag_next;
  logic [3:0] irq_en_reg;
  logic [3:0] irq_en_next;
  logic [2:0] port_out_reg;
  logic [2:0] port_out_next;
  logic [2:0] port_dir_reg;
  logic [2:0] port_dir_next;
  logic [2:0] wave_reg;
  logic [2:0] wave_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [2:0] pin_out_reg;
  logic [2:0] pin_out_next;
  logic [2:0] pin_oe_reg;
  logic [2:0] pin_oe_next;
  logic [3:0] irq_reg;
  logic [3:0] irq_next;
  logic [NUM_CHAN-1:0][15:0] compare_value_reg;
  logic [NUM_CHAN-1:0][15:0] compare_value_next;
  logic [NUM_CHAN-1:0][15:0] compare_buf_reg;
  logic [NUM_CHAN-1:0][15:0] compare_buf_next;

  logic pwm_mode;
  logic clear_at_top;
  logic [15:0] top_value;
  logic top_hit;
  logic counter_write;
  logic force_write;
  logic [2:0] match;
  logic [3:0] flag_set;
  logic [3:0] flag_clear;

  // One step of a channel's waveform bit; BOTTOM handling in PWM overrides a match.
  function automatic logic wave_step(input logic [1:0] act, input logic pwm,
                                     input logic hit, input logic bottom,
                                     input logic cur);
    logic res;
    res = cur;
    if (!pwm) begin
      if (hit) begin
        case (act)
          ACT_TOGGLE: res = ~cur; // R15
          ACT_CLEAR: res = 1'b0; // R15
          ACT_SET: res = 1'b1; // R15
          default: res = cur; // R12
        endcase
      end
    end else begin
      if (hit && act == ACT_CLEAR) begin
        res = 1'b0; // R15
      end else if (hit && act == ACT_SET) begin
        res = 1'b1; // R15
      end
      if (bottom && act == ACT_CLEAR) begin
        res = 1'b1;
      end else if (bottom && act == ACT_SET) begin
        res = 1'b0;
      end
    end
    return res;
  endfunction

  // Mode decode reads only the mode bits and compare A, so action selects cannot steer counting.
  always_comb begin
    pwm_mode = !(mode_reg == `T16_MODE_NORMAL || mode_reg == `T16_MODE_CTC_CMP ||
                 mode_reg == `T16_MODE_CTC_CAP); // R19
    clear_at_top = (mode_reg != `T16_MODE_NORMAL); // R14
    case (mode_reg)
      `T16_MODE_CTC_CMP: top_value = compare_value_reg[0];
      `T16_MODE_FAST_CMP: top_value = compare_value_reg[0];
      `T16_MODE_FAST_8: top_value = `T16_TOP_8BIT;
      `T16_MODE_FAST_9: top_value = `T16_TOP_9BIT;
      `T16_MODE_FAST_10: top_value = `T16_TOP_10BIT;
      default: top_value = `T16_TOP_MAX; // R16
    endcase
  end

  // A blocked tick also blocks the TOP match, so the counter runs on past TOP.
  assign top_hit = i_timer_tick && !block_reg && clear_at_top &&
                   (counter_value_reg == top_value); // R6
  assign counter_write = i_bus.wr && (i_bus.addr == `T16_ADDR_CNT_LO);
  assign force_write = i_bus.wr && (i_bus.addr == `T16_ADDR_FORCE);

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
      localparam logic [7:0] LoAddr = 8'(`T16_ADDR_CMP_BASE + 2 * ch);
      logic cmp_write;
      logic forced;
      logic [1:0] act;
      assign act = action_reg[2*ch +: 2]; // R13
      assign cmp_write = i_bus.wr && (i_bus.addr == LoAddr);
      assign compare_buf_next[ch] = cmp_write ? {temp_reg, i_bus.wdata} :
                                    compare_buf_reg[ch]; // R3
      assign compare_value_next[ch] = (cmp_write && !pwm_mode) ? {temp_reg, i_bus.wdata} :
                                      (pwm_mode && top_hit) ? compare_buf_reg[ch] :
                                      compare_value_reg[ch]; // R1 R19
      assign match[ch] = i_timer_tick && !block_reg &&
                         (counter_value_reg == compare_value_reg[ch]); // R5 R20
      assign forced = force_write && i_bus.wdata[ch] && !pwm_mode; // R4
      assign wave_next[ch] = wave_step(act, pwm_mode, match[ch] || forced,
                                       top_hit, wave_reg[ch]); // R8
      assign pin_out_next[ch] = (act != ACT_NONE) ? wave_reg[ch] :
                                port_out_reg[ch]; // R10
      assign pin_oe_next[ch] = port_dir_reg[ch]; // R11
    end
  endgenerate

  always_comb begin
    action_next = action_reg;
    mode_next = mode_reg;
    irq_en_next = irq_en_reg;
    port_out_next = port_out_reg;
    port_dir_next = port_dir_reg;
    temp_next = temp_reg;
    counter_value_next = counter_value_reg;
    block_next = block_reg;
    rdata_next = `T16_RST_BYTE;
    flag_set = `T16_RST_NIBBLE;
    flag_clear = i_irq_ack; // R21

    if (i_bus.wr) begin
      if (i_bus.addr == `T16_ADDR_ACTION) begin
        action_next = i_bus.wdata[5:0]; // R8
      end else if (i_bus.addr == `T16_ADDR_MODE) begin
        mode_next = i_bus.wdata[3:0]; // R7
      end else if (i_bus.addr == `T16_ADDR_CNT_HI) begin
        temp_next = i_bus.wdata; // R3
      end else if (i_bus.addr == `T16_ADDR_FLAGS) begin
        flag_clear = flag_clear | i_bus.wdata[3:0]; // R21
      end else if (i_bus.addr == `T16_ADDR_IRQ_EN) begin
        irq_en_next = i_bus.wdata[3:0];
      end else if (i_bus.addr == `T16_ADDR_PORT_OUT) begin
        port_out_next = i_bus.wdata[2:0];
      end else if (i_bus.addr == `T16_ADDR_PORT_DIR) begin
        port_dir_next = i_bus.wdata[2:0];
      end else if (i_bus.addr >= `T16_ADDR_CMP_BASE && i_bus.addr < `T16_ADDR_FLAGS &&
                   i_bus.addr[0] == 1'b0) begin
        temp_next = i_bus.wdata; // R3
      end
    end

    // The counter may be written in any state of the count; the write wins over a tick.
    if (counter_write) begin
      counter_value_next = {temp_reg, i_bus.wdata}; // R18
      block_next = 1'b1; // R22
    end else if (i_timer_tick) begin
      counter_value_next = top_hit ? `T16_BOTTOM : counter_value_reg + 16'h0001; // R16
      block_next = 1'b0; // R22
    end

    if (i_timer_tick && !counter_write) begin
      if (pwm_mode) begin
        flag_set[`T16_FLAG_OVF_BIT] = top_hit || counter_value_reg == `T16_TOP_MAX; // R17
      end else begin
        flag_set[`T16_FLAG_OVF_BIT] = (counter_value_reg == `T16_TOP_MAX); // R17
      end
    end
    flag_set[3:1] = match; // R20

    if (i_bus.rd) begin
      if (i_bus.addr == `T16_ADDR_ACTION) begin
        rdata_next = {2'h0, action_reg};
      end else if (i_bus.addr == `T16_ADDR_MODE) begin
        rdata_next = {4'h0, mode_reg};
      end else if (i_bus.addr == `T16_ADDR_CNT_LO) begin
        rdata_next = counter_value_reg[7:0];
        temp_next = counter_value_reg[15:8];
      end else if (i_bus.addr == `T16_ADDR_CNT_HI) begin
        rdata_next = temp_reg;
      end else if (i_bus.addr == `T16_ADDR_FLAGS) begin
        rdata_next = {4'h0, flag_reg};
      end else if (i_bus.addr == `T16_ADDR_IRQ_EN) begin
        rdata_next = {4'h0, irq_en_reg};
      end else if (i_bus.addr == `T16_ADDR_PORT_OUT) begin
        rdata_next = {5'h00, port_out_reg};
      end else if (i_bus.addr == `T16_ADDR_PORT_DIR) begin
        rdata_next = {5'h00, port_dir_reg};
      end else begin
        for (int i = 0; i < NUM_CHAN; i++) begin
          if (i_bus.addr == 8'(`T16_ADDR_CMP_BASE + 2 * i)) begin
            rdata_next = pwm_mode ? compare_buf_reg[i][7:0] :
                         compare_value_reg[i][7:0]; // R2
          end else if (i_bus.addr == 8'(`T16_ADDR_CMP_BASE + 2 * i + 1)) begin
            rdata_next = pwm_mode ? compare_buf_reg[i][15:8] :
                         compare_value_reg[i][15:8]; // R2
          end
        end
      end
    end

    // A flag raised in the same cycle as its clear survives.
    flag_next = (flag_reg & ~flag_clear) | flag_set; // R21
    irq_next = flag_next & irq_en_next; // R20
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      action_reg <= `T16_RST_ACTION;
      mode_reg <= `T16_RST_MODE;
      counter_value_reg <= `T16_RST_WORD;
      temp_reg <= `T16_RST_BYTE;
      block_reg <= 1'b0;
      flag_reg <= `T16_RST_NIBBLE;
      irq_en_reg <= `T16_RST_NIBBLE;
      port_out_reg <= `T16_RST_CHAN;
      port_dir_reg <= `T16_RST_CHAN;
      wave_reg <= `T16_RST_CHAN; // R9
      rdata_reg <= `T16_RST_BYTE;
      pin_out_reg <= `T16_RST_CHAN;
      pin_oe_reg <= `T16_RST_CHAN;
      irq_reg <= `T16_RST_NIBBLE;
      compare_value_reg <= '0;
      compare_buf_reg <= '0;
    end else begin
      action_reg <= action_next;
      mode_reg <= mode_next;
      counter_value_reg <= counter_value_next;
      temp_reg <= temp_next;
      block_reg <= block_next;
      flag_reg <= flag_next;
      irq_en_reg <= irq_en_next;
      port_out_reg <= port_out_next;
      port_dir_reg <= port_dir_next;
      wave_reg <= wave_next;
      rdata_reg <= rdata_next;
      pin_out_reg <= pin_out_next;
      pin_oe_reg <= pin_oe_next;
      irq_reg <= irq_next;
      compare_value_reg <= compare_value_next;
      compare_buf_reg <= compare_buf_next;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_pin_out = pin_out_reg;
  assign o_pin_oe = pin_oe_reg;
  assign o_irq = irq_reg;

endmodule // timer16_output_compare_unit

// ==== common/timer16_cfg.svh ====
// Register offsets, field positions, reset values and fixed counts of the compare timer.
`ifndef TIMER16_CFG_SVH
`define TIMER16_CFG_SVH

`define T16_ADDR_ACTION 8'h00
`define T16_ADDR_MODE 8'h01
`define T16_ADDR_FORCE 8'h02
`define T16_ADDR_CNT_LO 8'h03
`define T16_ADDR_CNT_HI 8'h04
`define T16_ADDR_CMP_BASE 8'h05
`define T16_ADDR_FLAGS 8'h0B
`define T16_ADDR_IRQ_EN 8'h0C
`define T16_ADDR_PORT_OUT 8'h0D
`define T16_ADDR_PORT_DIR 8'h0E

`define T16_FLAG_OVF_BIT 0
`define T16_FLAG_MATCH_LSB 1

`define T16_MODE_NORMAL 4'h0
`define T16_MODE_CTC_CMP 4'h4
`define T16_MODE_FAST_8 4'h5
`define T16_MODE_FAST_9 4'h6
`define T16_MODE_FAST_10 4'h7
`define T16_MODE_CTC_CAP 4'h C
`define T16_MODE_FAST_CMP 4'hF

`define T16_TOP_MAX 16'hFFFF
`define T16_TOP_8BIT 16'h00FF
`define T16_TOP_9BIT 16'h01FF
`define T16_TOP_10BIT 16'h03FF
`define T16_BOTTOM 16'h0000

`define T16_RST_BYTE 8'h00
`define T16_RST_WORD 16'h0000
`define T16_RST_MODE 4'h0
`define T16_RST_ACTION 6'h00
`define T16_RST_NIBBLE 4'h0
`define T16_RST_CHAN 3'h0

`endif

// ==== common/timer16_pkg.sv ====
// Types shared by the compare timer and its register port.
package timer16_pkg;

  typedef enum logic [1:0] {
    ACT_NONE = 2'h0,
    ACT_TOGGLE = 2'h1,
    ACT_CLEAR = 2'h2,
    ACT_SET = 2'h3
  } action_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;

  localparam int NUM_CHAN = 3;

endpackage

// ==== verif/timer16_output_compare_unit_properties.sv ====
// Port-level checks on the compare timer, bound into its top module.
`timescale 1ns/1ps
module timer16_output_compare_unit_chk (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_timer_tick,
  input wire timer16_pkg::bus_req_s i_bus,
  input wire logic [3:0] i_irq_ack,
  input wire logic [7:0] o_rdata,
  input wire logic [2:0] o_pin_out,
  input wire logic [2:0] o_pin_oe,
  input wire logic [3:0] o_irq
);
  import timer16_pkg::*;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  logic quiet;
  logic dir_wr;
  logic [2:0] wd3;
  assign quiet = !i_timer_tick && !i_bus.wr;
  assign dir_wr = i_bus.wr && i_bus.addr == 8'h0E;
  assign wd3 = i_bus.wdata[2:0];
  sequence seq_cmp_load;
    (i_bus.wr && i_bus.addr == 8'h06) ##1 (i_bus.wr && i_bus.addr == 8'h05);
  endsequence
  sequence seq_ack_ovf;
    (i_irq_ack[0] && !i_timer_tick) ##1 !i_timer_tick;
  endsequence
  a_cmp_word_load: assert property (
    seq_cmp_load ##2 (i_bus.rd && i_bus.addr == 8'h05) |=> o_rdata == $past(i_bus.wdata, 3))
    else $error("compare low byte readback wrong");
  a_rdata_idle: assert property (
    !$past(i_bus.rd) |-> o_rdata == 8'h00) else $error("read data outside its slot");
  a_unmapped_rd: assert property (
    i_bus.rd && (i_bus.addr == 8'h02 || i_bus.addr > 8'h0E) |=> o_rdata == 8'h00)
    else $error("empty location read nonzero");
  a_oe_from_dir: assert property (
    $past(dir_wr, 2) |-> o_pin_oe == $past(wd3, 2)) else $error("pin enable not direction");
  a_pin_quiet: assert property (
    quiet [*5] |-> $stable(o_pin_out)) else $error("pin moved with no cause");
  a_irq_quiet: assert property (
    (quiet && i_irq_ack == 4'h0) [*4] |-> $stable(o_irq)) else $error("request moved alone");
  a_force_no_flag: assert property (
    (i_bus.wr && i_bus.addr == 8'h02 && !i_timer_tick) ##1 quiet [*3]
    |-> (o_irq & ~$past(o_irq)) == 4'h0) else $error("force raised a request");
  a_ack_clears: assert property (
    seq_ack_ovf |=> !o_irq[0]) else $error("acknowledge left request up");
endmodule // timer16_output_compare_unit_chk
bind timer16_output_compare_unit timer16_output_compare_unit_chk u_chk (.i_mclk(i_mclk),
  .i_reset_n(i_reset_n), .i_timer_tick(i_timer_tick), .i_bus(i_bus), .i_irq_ack(i_irq_ack),
  .o_rdata(o_rdata), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_irq(o_irq));

// ==== verif/timer16_cpu_model.sv ====
// Processor-side model issuing byte requests and interrupt acknowledges.
`timescale 1ns/1ps
module timer16_cpu_model (
  input wire logic i_mclk,
  input wire logic [7:0] i_rdata,
  output timer16_pkg::bus_req_s o_bus,
  output logic [3:0] o_irq_ack
);
  import timer16_pkg::*;
  initial begin
    o_bus = '0;
    o_irq_ack = 4'h0;
  end
  // Tasks start just after an edge; each leaves one idle edge so strobes never merge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    o_bus <= '{a, d, 1'b1, 1'b0};
    @(posedge i_mclk);
    o_bus <= '0;
    @(posedge i_mclk);
  endtask
  // The high byte must reach the staging byte before the low byte commits the word.
  task automatic wr2(input logic [7:0] a, input logic [7:0] hi, input logic [7:0] lo);
    o_bus <= '{a + 8'h01, hi, 1'b1, 1'b0};
    @(posedge i_mclk);
    o_bus <= '{a, lo, 1'b1, 1'b0};
    @(posedge i_mclk);
    o_bus <= '0;
    @(posedge i_mclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    o_bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge i_mclk);
    o_bus <= '0;
    // Read data stand for one cycle only; take them mid-cycle, clear of the edge race.
    @(negedge i_mclk);
    d = i_rdata;
    @(posedge i_mclk);
  endtask
  task automatic ack(input logic [3:0] m);
    o_irq_ack <= m;
    @(posedge i_mclk);
    o_irq_ack <= 4'h0;
    @(posedge i_mclk);
  endtask
endmodule // timer16_cpu_model

// ==== verif/test_timer16_output_compare_unit.sv ====
// Self-checking bench for the compare timer driven through the processor model.
`timescale 1ns/1ps
module test_timer16_output_compare_unit;
  import timer16_pkg::*;
  logic i_mclk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_timer_tick = 1'b0;
  bus_req_s bus;
  logic [3:0] ack;
  logic [3:0] o_irq;
  logic [7:0] o_rdata;
  logic [7:0] d;
  logic [2:0] o_pin_out;
  logic [2:0] o_pin_oe;
  int bad_count = 0;
  int samples_checked = 0;
  always #10 i_mclk = ~i_mclk;
  timer16_output_compare_unit u_dut (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
    .i_timer_tick(i_timer_tick), .i_bus(bus), .i_irq_ack(ack), .o_rdata(o_rdata),
    .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_irq(o_irq));
  timer16_cpu_model u_cpu (.i_mclk(i_mclk), .i_rdata(o_rdata), .o_bus(bus), .o_irq_ack(ack));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string what);
    u_cpu.rd(a, d);
    check(what, d, exp);
  endtask
  task automatic tick(input int n);
    i_timer_tick <= 1'b1;
    repeat (n) @(posedge i_mclk);
    i_timer_tick <= 1'b0;
    @(posedge i_mclk);
  endtask
  task automatic settle();
    repeat (3) @(posedge i_mclk);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic s_reset();
    check("pins", {2'b00, o_pin_out, o_pin_oe}, 8'h00);
    rchk(8'h20, 8'h00, "unmapped");
  endtask
  task automatic s_compare_access();
    u_cpu.wr2(8'h05, 8'h12, 8'h34);
    rchk(8'h05, 8'h34, "cmpa lo");
    rchk(8'h03, 8'h00, "cnt lo");
    rchk(8'h06, 8'h12, "cmpa hi");
  endtask
  task automatic s_overflow();
    u_cpu.wr(8'h0C, 8'h01);
    u_cpu.wr2(8'h03, 8'hFF, 8'hFE);
    tick(2);
    rchk(8'h0B, 8'h01, "ovf");
    check("irq ovf", 8'(o_irq), 8'h01);
    rchk(8'h03, 8'h00, "cnt lo");
    rchk(8'h04, 8'h00, "cnt hi");
    u_cpu.ack(4'h1);
    rchk(8'h0B, 8'h00, "ovf clr");
  endtask
  task automatic s_actions();
    u_cpu.wr(8'h0E, 8'h01);
    // Set, clear, toggle in turn, each applied through the force strobe.
    for (int i = 0; i < 3; i++) begin
      u_cpu.wr(8'h00, 8'(3 - i));
      u_cpu.wr(8'h02, 8'h01);
      settle();
      check("pin", 8'(o_pin_out), {7'h0, ~i[0]});
    end
    check("oe", 8'(o_pin_oe), 8'h01);
    rchk(8'h0B, 8'h00, "no flag");
    rchk(8'h03, 8'h00, "cnt kept");
    u_cpu.wr(8'h00, 8'h00);
    u_cpu.wr(8'h02, 8'h01);
    settle();
    check("port", 8'(o_pin_out), 8'h00);
    u_cpu.wr(8'h00, 8'h01);
    settle();
    check("wave kept", 8'(o_pin_out), 8'h01);
    u_cpu.wr(8'h01, 8'h05);
    u_cpu.wr(8'h01, 8'h00);
    settle();
    check("mode chg", 8'(o_pin_out), 8'h01);
  endtask
  task automatic s_block();
    u_cpu.wr2(8'h05, 8'h00, 8'h05);
    u_cpu.wr(8'h0C, 8'h02);
    u_cpu.wr2(8'h03, 8'h00, 8'h05);
    tick(1);
    rchk(8'h0B, 8'h00, "blocked");
    u_cpu.wr2(8'h03, 8'h00, 8'h04);
    tick(1);
    tick(1);
    rchk(8'h0B, 8'h02, "match");
    check("irq", 8'(o_irq), 8'h02);
    u_cpu.wr(8'h0B, 8'h02);
    settle();
    check("irq clr", 8'(o_irq), 8'h00);
  endtask
  task automatic s_pwm();
    // Fast PWM with compare A as TOP: writes land in the buffer only.
    u_cpu.wr(8'h01, 8'h0F);
    u_cpu.wr2(8'h05, 8'h00, 8'h09);
    rchk(8'h05, 8'h09, "buf rd");
    // Counter written equal to TOP: that TOP is skipped and counting goes on.
    u_cpu.wr2(8'h03, 8'h00, 8'h05);
    tick(2);
    rchk(8'h03, 8'h07, "top skip");
    u_cpu.wr(8'h01, 8'h00);
    rchk(8'h05, 8'h05, "live kept");
  endtask
  initial begin
    repeat (6) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    @(posedge i_mclk);
    s_reset();
    s_compare_access();
    s_overflow();
    s_actions();
    s_block();
    s_pwm();
    report_and_stop();
  end
  initial begin
    repeat (2000) @(posedge i_mclk);
    bad_count++;
    report_and_stop();
  end
endmodule // test_timer16_output_compare_unit
